// ===== dv/drf_timing_model.sv
// Access timing model: raises the access-ready mark a set number of
// cycles after a cycle opens. Assumes the sequencer's clock and done.
module drf_timing_model
(
	input wire logic clock,
	input wire logic busy,
	input wire logic cycle_done,
	input wire logic [3:0] delay,
	output logic access_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] count_q = 4'h0;
	logic open_q = 1'b0;
	logic open_now;

	// An access stays open from its start until done, even after the host
	// lets go of its request, so the mark can still end the host cycle.
	assign open_now = busy || open_q;

	// Done closes the access; a request or refresh opens it.
	always @(posedge clock)
	begin
		if (cycle_done)
			open_q <= 1'b0;
		else if (busy)
			open_q <= 1'b1;
	end

	// Counting restarts at each done, so a resumed access is timed again.
	always @(posedge clock)
	begin
		if (!open_now || cycle_done)
			count_q <= 4'h0;
		else if (count_q != 4'hf)
			count_q <= count_q + 4'h1;
	end

	// The mark holds while the access stays open, like a stalled step.
	assign access_ready = open_now && !cycle_done && (count_q >= delay);
endmodule : drf_timing_model

// ===== dv/dynamic_memory_refresh_logic_test.sv
// Self-checking bench for the refresh sequencer and its timing model.
// Assumes short tick and watchdog counts; inputs move on falling edges.
module dynamic_memory_refresh_logic_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 100;
	localparam int OVR = 20;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic bipolar_select = 1'b0;
	logic supply_low_warning = 1'b0;
	logic processor_request = 1'b0;
	logic parity_bad = 1'b0;
	logic control_valid = 1'b0;
	logic write_request = 1'b0;
	logic [7:0] host_address = 8'h00;
	logic [3:0] delay = 4'h3;
	logic access_ready, refresh_request_latched, refresh_in_progress;
	logic refresh_row_select, chip_enable_strobe, write_pulse, cycle_done;
	logic refresh_overdue, parity_error_flag, prev_l;
	logic [4:0] refresh_row_count;
	logic [7:0] matrix_address;
	logic [3:0] matrix_gating_levels;
	int failures = 0;
	int total_checks = 0;
	int cyc = 0;
	int last_rise = 0;
	int exp_q[$];
	bit gap_on = 1'b0;
	bit rand_on = 1'b0;

	drf_refresh #(.TICK_CYCLES(TICK), .OVERDUE_CYCLES(OVR)) DUT (
		.clock(clock), .nrst(nrst), .bipolar_select(bipolar_select),
		.supply_low_warning(supply_low_warning),
		.processor_request(processor_request), .access_ready(access_ready),
		.parity_bad(parity_bad), .control_valid(control_valid),
		.write_request(write_request), .host_address(host_address),
		.refresh_request_latched(refresh_request_latched),
		.refresh_in_progress(refresh_in_progress),
		.refresh_row_select(refresh_row_select),
		.refresh_row_count(refresh_row_count),
		.matrix_address(matrix_address),
		.matrix_gating_levels(matrix_gating_levels),
		.chip_enable_strobe(chip_enable_strobe), .write_pulse(write_pulse),
		.cycle_done(cycle_done), .refresh_overdue(refresh_overdue),
		.parity_error_flag(parity_error_flag));

	drf_timing_model timing (.clock(clock), .cycle_done(cycle_done),
		.busy(refresh_request_latched | processor_request),
		.delay(delay), .access_ready(access_ready));

	// ----
	// Shared tasks
	// ----
	always #5 clock = ~clock;

	task check_val(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task check_len(input string what, input int exp, input int got);
		total_checks++;
		if (got != exp)
		begin
			failures++;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_len

	task close_out;
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	// Every wait is bounded; running out ends the run as a failure.
	task wait_for(input int which, input int bound);
		int n;
		logic s;
		n = 0;
		s = 1'b0;
		while (!s)
		begin
			@(negedge clock);
			case (which)
				0: s = refresh_request_latched === 1'b1;
				1: s = refresh_request_latched === 1'b0;
				2: s = access_ready === 1'b1;
				3: s = cycle_done === 1'b1;
				default: s = refresh_overdue === 1'b1;
			endcase
			n++;
			if (!s && n >= bound)
			begin
				check_len("wait", which, -1);
				close_out();
			end
		end
	endtask : wait_for

	// Parity and write noise, so refresh must ignore both.
	always @(negedge clock)
		if (rand_on)
		begin
			write_request <= 1'($urandom);
			parity_bad <= 1'($urandom);
			control_valid <= 1'($urandom);
		end

	// ----
	// Watcher: each refresh start takes the oldest note off the queue
	// ----
	// Cycle count moves on the rising edge, so falling-edge readers agree.
	always @(posedge clock)
		cyc++;

	// Refresh starts are checked at the falling edge, where outputs settle.
	always @(negedge clock)
	begin
		int e;
		if (nrst && refresh_request_latched && !prev_l)
		begin
			if (exp_q.size() == 0)
				check_len("unexpected refresh", 0, 1);
			else
			begin
				e = exp_q.pop_front();
				if (e >= 0)
					check_val("row", 8'(e % 32), {3'h0, refresh_row_count});
				check_val("address", {refresh_row_count, 3'h0}, matrix_address);
				check_val("gating", 8'h0f, {4'h0, matrix_gating_levels});
				check_val("strobes", 8'h07, {5'h00, refresh_in_progress,
					refresh_row_select, chip_enable_strobe});
				if (gap_on)
					check_len("tick gap", TICK, cyc - last_rise);
			end
			last_rise = cyc;
		end
		if (refresh_request_latched && prev_l)
			check_val("quiet", 8'h00, {6'h00, write_pulse, parity_error_flag});
		prev_l = refresh_request_latched;
	end

	// Main sequence: rows, host blocking, watchdog, supply low, bipolar.
	initial
	begin
		int base, k, len;
		void'($urandom(40));
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		@(negedge clock);
		check_val("reset", 8'h00, {refresh_request_latched, cycle_done,
			refresh_overdue, refresh_row_count});
		rand_on = 1'b1;
		exp_q.push_back(-1);
		wait_for(0, 3 * TICK);
		base = refresh_row_count;
		// Past a full wrap of the rows, one refresh per tick.
		for (k = 1; k <= 33; k++)
		begin
			exp_q.push_back(base + k);
			wait_for(1, 40);
			gap_on = 1'b1;
			delay = 4'($urandom_range(1, 12));
			wait_for(0, TICK + 5);
		end
		rand_on = 1'b0;
		base = base + 33;
		wait_for(1, 40);
		gap_on = 1'b0;
		host_address = 8'($urandom);
		{write_request, parity_bad, control_valid} = 3'b111;
		processor_request = 1'b1;
		wait_for(2, 20);
		repeat (2) @(negedge clock);
		check_val("host address", host_address, matrix_address);
		check_val("host flags", 8'h03, {6'h00, write_pulse, parity_error_flag});
		processor_request = 1'b0;
		wait_for(3, 5);
		{write_request, parity_bad, control_valid} = 3'b000;
		// A host access across the tick holds the refresh back.
		while (cyc < last_rise + TICK - 12)
			@(negedge clock);
		exp_q.push_back(base + 1);
		processor_request = 1'b1;
		repeat (20) @(negedge clock);
		check_val("blocked", 8'h00, {7'h00, refresh_request_latched});
		processor_request = 1'b0;
		wait_for(0, 20);
		wait_for(1, 40);
		// A stalled access is broken into by the watchdog.
		// The last refresh started late, so the margin to the tick is wider.
		while (cyc < last_rise + TICK - 24)
			@(negedge clock);
		exp_q.push_back(base + 2);
		processor_request = 1'b1;
		wait_for(4, TICK);
		wait_for(0, 5);
		len = 0;
		while (refresh_request_latched === 1'b1 && len < 60)
		begin
			@(negedge clock);
			len++;
		end
		check_len("steal length", 1, int'(len >= 44 && len <= 47));
		@(negedge clock);
		check_val("resumed", host_address, matrix_address);
		len = 0;
		repeat (30)
		begin
			@(negedge clock);
			len += int'(refresh_overdue === 1'b1);
		end
		check_len("second overdue", 0, len);
		processor_request = 1'b0;
		wait_for(3, 20);
		// The next tick refreshes as normal once the host has let go.
		exp_q.push_back(base + 3);
		wait_for(0, TICK + 5);
		wait_for(1, 40);
		supply_low_warning = 1'b1;
		repeat (3 * TICK) @(negedge clock);
		supply_low_warning = 1'b0;
		exp_q.push_back(base + 4);
		wait_for(0, 2 * TICK);
		bipolar_select = 1'b1;
		repeat (3 * TICK) @(negedge clock);
		bipolar_select = 1'b0;
		exp_q.push_back(-1);
		wait_for(0, 2 * TICK);
		wait_for(1, 40);
		check_len("pending notes", 0, exp_q.size());
		close_out();
	end
endmodule : dynamic_memory_refresh_logic_test

// ===== hdl/drf_pkg.sv
// Constants for the dynamic memory refresh sequencer.
// Assumes a 100 MHz controller clock; shared by the sequencer and its timer.
package drf_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_US = 30;
	localparam int OVERDUE_US = 15;
	localparam int WRITE_BLOCK_NS = 60;
	localparam int STEAL_NS = 450;
	localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int OVERDUE_CYCLES = OVERDUE_US * 1000 / CLK_PERIOD_NS;
	// A least time rounds up.
	localparam int WRITE_BLOCK_CYCLES =
		(WRITE_BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEAL_CYCLES = STEAL_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------------
	localparam int ROW_BITS = 5;
	localparam int ROWS = 32;
	localparam int MODULES = 4;
	localparam int ADDR_BITS = 8;
	localparam int ROW_LSB = 3;
	localparam int SECTION_WORDS = 1024;
	localparam int WORDS_PER_REFRESH = 128;
	localparam logic [ROW_BITS-1:0] ROW_RESET = 5'h00;

	// ------------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		DRF_IDLE = 2'b00,
		DRF_HOST = 2'b01,
		DRF_REFRESH = 2'b10,
		DRF_STEAL = 2'b11
	} drf_state_type;

endpackage : drf_pkg

// ===== hdl/drf_refresh.sv
// Refresh sequencer of a dynamic MOS memory controller.
// Assumes the host access timing sits outside: it reports access start,
// access-ready and takes cycle done. All inputs are synchronous.

// Functional notes
// - Cycle all rows, each cell within a millisecond.
// - No refresh while bipolar matrix is selected.
// - One row addressed on all modules together.
// - Free-running 30 us tick paces refresh.
// - Tick sets request flag, gated by dynamic; here every tick sets it and dynamic gates only the latch and watchdog.
// - Latched request starts cycle, drives row count.
// - Access in progress blocks request latching.
// - Block write pulses 60 ns after latch.
// - Done pulse clears flag until next tick.
// - Five-bit row counter advances each tick.
// - Refresh drives every matrix gating level active.
// - Each refresh covers 128 words total.
// - Access ready in refresh gives cycle done.
// - Next refresh waits for next tick edge.
// - Request starts 15 us overdue timer.
// - Overdue forces done, lets refresh latch; here overdue latches the refresh at once and done comes only at steal end.
// - Stolen refresh lasts about 450 ns.
// - Stalled access resumes unchanged after refresh.
// - Steal completion clears flag, cancels timer.
// - Refresh continues in power-down unless supply low.
// - Refresh cycles never report parity errors, save the first cycle of a stolen one.
module drf_refresh #(
	parameter int TICK_CYCLES = drf_pkg::TICK_CYCLES,
	parameter int OVERDUE_CYCLES = drf_pkg::OVERDUE_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic bipolar_select,
	input wire logic supply_low_warning,
	input wire logic processor_request,
	input wire logic access_ready,
	input wire logic parity_bad,
	input wire logic control_valid,
	input wire logic write_request,
	input wire logic [drf_pkg::ADDR_BITS-1:0] host_address,
	output logic refresh_request_latched,
	output logic refresh_in_progress,
	output logic refresh_row_select,
	output logic [drf_pkg::ROW_BITS-1:0] refresh_row_count,
	output logic [drf_pkg::ADDR_BITS-1:0] matrix_address,
	output logic [drf_pkg::MODULES-1:0] matrix_gating_levels,
	output logic chip_enable_strobe,
	output logic write_pulse,
	output logic cycle_done,
	output logic refresh_overdue,
	output logic parity_error_flag
);

	// ------------------------------------------------------------------
	// Local constants
	// ------------------------------------------------------------------
	localparam int RB = drf_pkg::ROW_BITS;
	localparam int AB = drf_pkg::ADDR_BITS;
	localparam int WB_BITS = $clog2(drf_pkg::WRITE_BLOCK_CYCLES + 1);
	localparam int ST_BITS = $clog2(drf_pkg::STEAL_CYCLES + 1);
	localparam logic [WB_BITS-1:0] WB_LAST =
		WB_BITS'(drf_pkg::WRITE_BLOCK_CYCLES);
	localparam logic [ST_BITS-1:0] ST_LAST =
		ST_BITS'(drf_pkg::STEAL_CYCLES - 1);
	localparam logic [drf_pkg::MODULES-1:0] ALL_GATES = '1;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	drf_pkg::drf_state_type state_q, state_d;
	logic req_flag_q, req_flag_d;
	logic [RB-1:0] row_q, row_d;
	logic [WB_BITS-1:0] wb_cnt_q, wb_cnt_d;
	logic [ST_BITS-1:0] st_cnt_q, st_cnt_d;
	logic [AB-1:0] maddr_q, maddr_d;
	logic [drf_pkg::MODULES-1:0] gates_q, gates_d;
	logic latched_q, latched_d;
	logic inprog_q, inprog_d;
	logic select_q, select_d;
	logic cen_q, cen_d;
	logic wr_q, wr_d;
	logic done_q, done_d;
	logic overdue_q, overdue_d;
	logic perr_q, perr_d;
	logic tick;
	logic od_expire;
	logic run_tick;
	logic dynamic;
	logic od_run;

	// The tick stops only on supply low; power-down alone keeps it going.
	assign run_tick = !supply_low_warning;
	assign dynamic = !bipolar_select;
	assign od_run = req_flag_q && dynamic && !supply_low_warning;

	// ------------------------------------------------------------------
	// Pacing tick and overdue watchdog
	// ------------------------------------------------------------------
	// Both are plain cycle counts so simulation may shorten them.
	drf_timer #(.COUNT(TICK_CYCLES), .FREE_RUN(1'b1)) u_tick (
		.clock(clock),
		.nrst(nrst),
		.run(run_tick),
		.restart(1'b0),
		.expire(tick)
	);

	drf_timer #(.COUNT(OVERDUE_CYCLES), .FREE_RUN(1'b0)) u_overdue (
		.clock(clock),
		.nrst(nrst),
		.run(od_run),
		.restart(1'b0),
		.expire(od_expire)
	);

	// ------------------------------------------------------------------
	// Request flag and row counter
	// ------------------------------------------------------------------
	// Set wins over clear, so a tick landing on the clearing cycle survives.
	always_comb
	begin
		req_flag_d = req_flag_q;
		row_d = row_q;
		if ((state_q == drf_pkg::DRF_REFRESH ||
			state_q == drf_pkg::DRF_STEAL) && done_d)
			req_flag_d = 1'b0;
		if (tick)
		begin
			req_flag_d = 1'b1;
			row_d = row_q + RB'(1);
		end
	end

	// ------------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------------
	// A host access in progress blocks the refresh latch. If the host
	// access stalls past the watchdog, a refresh is stolen from it and
	// the host access resumes afterwards with its levels untouched.
	always_comb
	begin
		state_d = state_q;
		wb_cnt_d = wb_cnt_q;
		st_cnt_d = st_cnt_q;
		done_d = 1'b0;
		overdue_d = 1'b0;
		case (state_q)
			drf_pkg::DRF_IDLE:
			begin
				wb_cnt_d = '0;
				st_cnt_d = '0;
				if (req_flag_q && dynamic)
					state_d = drf_pkg::DRF_REFRESH;
				else if (processor_request)
					state_d = drf_pkg::DRF_HOST;
			end
			drf_pkg::DRF_HOST:
			begin
				// The host owns the cycle, so the refresh latch is held off.
				if (od_expire && access_ready)
				begin
					overdue_d = 1'b1;
					state_d = drf_pkg::DRF_STEAL;
				end
				else if (access_ready && !processor_request)
				begin
					done_d = 1'b1;
					state_d = drf_pkg::DRF_IDLE;
				end
			end
			drf_pkg::DRF_REFRESH:
			begin
				if (wb_cnt_q != WB_LAST)
					wb_cnt_d = wb_cnt_q + WB_BITS'(1);
				if (access_ready && wb_cnt_q == WB_LAST)
				begin
					done_d = 1'b1;
					state_d = drf_pkg::DRF_IDLE;
				end
			end
			drf_pkg::DRF_STEAL:
			begin
				st_cnt_d = st_cnt_q + ST_BITS'(1);
				if (st_cnt_q == ST_LAST)
				begin
					done_d = 1'b1;
					st_cnt_d = '0;
					state_d = drf_pkg::DRF_HOST;
				end
			end
			default:
				state_d = drf_pkg::DRF_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// Output levels
	// ------------------------------------------------------------------
	// During refresh every module is gated and the row count sits on
	// address bits 7:3, so one row refreshes on all four modules.
	always_comb
	begin
		latched_d = state_d == drf_pkg::DRF_REFRESH ||
			state_d == drf_pkg::DRF_STEAL;
		inprog_d = latched_d;
		select_d = latched_d;
		maddr_d = host_address;
		gates_d = '0;
		cen_d = processor_request || latched_d;
		if (latched_d)
		begin
			maddr_d = '0;
			maddr_d[drf_pkg::ROW_LSB +: RB] = row_d;
			gates_d = ALL_GATES;
		end
		else if (processor_request)
			gates_d = ALL_GATES;
		// Writes pass only in a host cycle, so they stop as soon as a request latches.
		wr_d = write_request && access_ready &&
			state_d == drf_pkg::DRF_HOST && !latched_d;
		// Errors only on processor cycles qualified by control valid.
		perr_d = parity_bad && control_valid &&
			state_q == drf_pkg::DRF_HOST;
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			state_q <= drf_pkg::DRF_IDLE;
			req_flag_q <= 1'b0;
			row_q <= drf_pkg::ROW_RESET;
			wb_cnt_q <= '0;
			st_cnt_q <= '0;
			maddr_q <= '0;
			gates_q <= '0;
			latched_q <= 1'b0;
			inprog_q <= 1'b0;
			select_q <= 1'b0;
			cen_q <= 1'b0;
			wr_q <= 1'b0;
			done_q <= 1'b0;
			overdue_q <= 1'b0;
			perr_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			req_flag_q <= req_flag_d;
			row_q <= row_d;
			wb_cnt_q <= wb_cnt_d;
			st_cnt_q <= st_cnt_d;
			maddr_q <= maddr_d;
			gates_q <= gates_d;
			latched_q <= latched_d;
			inprog_q <= inprog_d;
			select_q <= select_d;
			cen_q <= cen_d;
			wr_q <= wr_d;
			done_q <= done_d;
			overdue_q <= overdue_d;
			perr_q <= perr_d;
		end
	end

	assign refresh_request_latched = latched_q;
	assign refresh_in_progress = inprog_q;
	assign refresh_row_select = select_q;
	assign refresh_row_count = row_q;
	assign matrix_address = maddr_q;
	assign matrix_gating_levels = gates_q;
	assign chip_enable_strobe = cen_q;
	assign write_pulse = wr_q;
	assign cycle_done = done_q;
	assign refresh_overdue = overdue_q;
	assign parity_error_flag = perr_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_bipolar_no_refresh: assert property (@(posedge clock)
		disable iff (!nrst)
		(bipolar_select && state_q == drf_pkg::DRF_IDLE) |=>
		!refresh_request_latched)
		else $error("refresh latched with bipolar matrix");

	a_refresh_address_row: assert property (@(posedge clock)
		disable iff (!nrst)
		refresh_row_select |->
		matrix_address[drf_pkg::ROW_LSB +: RB] == refresh_row_count)
		else $error("row count not on matrix address");

	a_refresh_all_gates: assert property (@(posedge clock)
		disable iff (!nrst)
		refresh_in_progress |-> matrix_gating_levels == ALL_GATES)
		else $error("gating levels not all active in refresh");

	a_refresh_no_write: assert property (@(posedge clock)
		disable iff (!nrst)
		refresh_request_latched |-> !write_pulse)
		else $error("write pulse during refresh");

	a_row_tick_step: assert property (@(posedge clock)
		disable iff (!nrst)
		tick |=> refresh_row_count == $past(refresh_row_count) + RB'(1))
		else $error("row counter did not advance on tick");

	a_flag_on_tick: assert property (@(posedge clock)
		disable iff (!nrst)
		tick |=> req_flag_q)
		else $error("request flag not set by tick");

	a_host_blocks_latch: assert property (@(posedge clock)
		disable iff (!nrst)
		(state_q == drf_pkg::DRF_HOST && !od_expire) |=>
		!refresh_request_latched)
		else $error("refresh latched during host access");

	a_overdue_steal: assert property (@(posedge clock)
		disable iff (!nrst)
		refresh_overdue |-> refresh_request_latched ##[44:46] cycle_done)
		else $error("stolen refresh length wrong");

	a_done_clears_flag: assert property (@(posedge clock)
		disable iff (!nrst)
		(cycle_done && $past(refresh_request_latched) && !$past(tick))
		|-> !req_flag_q)
		else $error("flag not cleared after refresh");

endmodule : drf_refresh

// ===== hdl/drf_timer.sv
// Reloadable down counter; expiry pulses one cycle when free-running, else stays high while run.
// Assumes a single clock and synchronous active-low reset.
module drf_timer #(
	parameter int COUNT = 3000,
	parameter bit FREE_RUN = 1'b1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic run,
	input wire logic restart,
	output logic expire
);

	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] TOP = W'(COUNT - 1);
	localparam logic [W-1:0] ZERO = '0;

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic expire_q;
	logic expire_d;

	// Count down while running; reload on restart or at zero when free.
	always_comb
	begin
		cnt_d = cnt_q;
		expire_d = 1'b0;
		if (restart || !run)
			cnt_d = TOP;
		else if (cnt_q == ZERO)
		begin
			expire_d = 1'b1;
			if (FREE_RUN)
				cnt_d = TOP;
		end
		else
			cnt_d = cnt_q - W'(1);
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			cnt_q <= TOP;
			expire_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			expire_q <= expire_d;
		end
	end

	assign expire = expire_q;

endmodule : drf_timer
